// *** infrared_comm_mode_pulse_codec_bench.sv ***
// Bench for the infrared pulse codec: registers, coding, receive filter, pass-through.
// Assumes the codec answers every handshake within a few dozen cycles.
module infrared_comm_mode_pulse_codec_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'h0, nrst = 1'h0, seen;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, txBitValid = 1'h0;
    logic        txBitData = 1'h1, eventIn = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        txBitReady, usartRx, irTx, irRx;
    int          bad_count = 0, check_count = 0, len, gap;
    always #10 clk = ~clk;
    ircp_codec ircp_codec_i (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txBitValid, .txBitData, .txBitReady,
        .usartRx, .irTx, .irRx, .eventIn);
    ircp_optics_model ircp_optics_model_i (.clk, .irTx, .irRx);
    task automatic complete_run;
        if (bad_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    // A used-up wait counts as a mismatch and ends the run
    task automatic guard(input int n);
        if (n > 250) begin
            bad_count++;
            $display("CHECK FAILED %0t wait timed out", $time);
            complete_run();
        end
    endtask : guard
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Write: address and data are each released at the edge that takes them
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic pa, pw, ta, tw;
        @(posedge clk);
        n = 0;
        pa = 1'h1;
        pw = 1'h1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (pa || pw) begin
            @(negedge clk);
            ta = pa & s_axi_awready;
            tw = pw & s_axi_wready;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            pa = pa & !ta;
            pw = pw & !tw;
            guard(++n);
        end
        do begin
            @(negedge clk);
            guard(++n);
        end while (s_axi_bvalid !== 1'h1);
        chk(s_axi_bresp, er);
        @(posedge clk);
        s_axi_bready <= 1'h0;
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge clk);
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(negedge clk);
            guard(++n);
        end while (s_axi_arready !== 1'h1);
        @(posedge clk);
        s_axi_arvalid <= 1'h0;
        do begin
            @(negedge clk);
            guard(++n);
        end while (s_axi_rvalid !== 1'h1);
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
        @(posedge clk);
        s_axi_rready <= 1'h0;
    endtask : axr
    task automatic push(input logic b);
        int n;
        @(posedge clk);
        n = 0;
        txBitValid <= 1'h1;
        txBitData <= b;
        do begin
            @(negedge clk);
            guard(++n);
        end while (txBitReady !== 1'h1);
        @(posedge clk);
        txBitValid <= 1'h0;
    endtask : push
    // Low cycles before the next transmit pulse, then its length
    task automatic measure(output int wt, output int cnt);
        wt = 0;
        cnt = 0;
        do begin
            @(negedge clk);
            guard(++wt);
        end while (irTx !== 1'h1);
        while (irTx === 1'h1 && cnt < 300) begin
            @(negedge clk);
            cnt++;
        end
    endtask : measure
    task automatic watch(input int cyc, input logic lv, output logic hit);
        hit = 1'h0;
        repeat (cyc) begin
            @(negedge clk);
            if (lv ? irTx === 1'h0 : usartRx === 1'h0) hit = 1'h1;
        end
    endtask : watch
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'h1;
        axr(8'h30, 32'h0, 2'h0);
        axr(8'h34, 32'h0, 2'h0);
        axr(8'h38, 32'h0, 2'h0);
        axr(8'h44, 32'h10, 2'h0);
        axr(8'h3C, 32'h0, 2'h2);
        axw(8'h48, 32'h1, 2'h0 | 2'h2);
        axw(8'h38, 32'hFF, 2'h0);
        axr(8'h38, 32'h7F, 2'h0);
        axw(8'h30, 32'h1, 2'h0);
        axr(8'h30, 32'h1, 2'h0);
        // Plain mode and the pass setting both leave both paths unchanged
        for (int i = 0; i < 2; i++) begin
            axw(8'h40, 32'h0, 2'h0);
            axw(8'h34, i ? 32'hFF : 32'h0, 2'h0);
            axw(8'h40, i ? 32'hE : 32'hC, 2'h0);
            ircp_optics_model_i.setLevel(1'h1);
            repeat (2) @(negedge clk);
            chk(usartRx, 1'h1);
            ircp_optics_model_i.setLevel(1'h0);
            repeat (2) @(negedge clk);
            chk(usartRx, 1'h0);
            push(1'h0);
            watch(40, 1'h1, seen);
            chk(seen, 1'h1);
        end
        // Fill the buffer with idle bits while stopped, then send zeros as pulses
        axw(8'h40, 32'h2, 2'h0);
        axw(8'h34, 32'h5, 2'h0);
        push(1'h1);
        push(1'h1);
        @(negedge clk);
        chk(txBitReady, 1'h0);
        axr(8'h48, 32'h4, 2'h0);
        axw(8'h40, 32'h6, 2'h0);
        push(1'h0);
        push(1'h0);
        measure(gap, len);
        chk(len, 5);
        measure(gap, len);
        chk(len, 5);
        chk(gap, 16 - 5);
        axw(8'h40, 32'h2, 2'h0);
        axw(8'h34, 32'h0, 2'h0);
        axw(8'h40, 32'h6, 2'h0);
        push(1'h0);
        measure(gap, len);
        chk(len, 16 * 3 / 16);
        // Receive filter: coefficient 3 needs four high samples
        axw(8'h40, 32'h2, 2'h0);
        axw(8'h38, 32'h3, 2'h0);
        axw(8'h40, 32'hA, 2'h0);
        ircp_optics_model_i.sendPulse(3);
        watch(30, 1'h0, seen);
        chk(seen, 1'h0);
        ircp_optics_model_i.sendPulse(4);
        watch(30, 1'h0, seen);
        chk(seen, 1'h1);
        // No filtering, event input enabled: one event sample is a pulse
        axw(8'h40, 32'h2, 2'h0);
        axw(8'h38, 32'h0, 2'h0);
        axw(8'h30, 32'h0, 2'h0);
        axw(8'h40, 32'hA, 2'h0);
        @(posedge clk);
        eventIn <= 1'h1;
        @(posedge clk);
        eventIn <= 1'h0;
        watch(30, 1'h0, seen);
        chk(seen, 1'h1);
        ircp_optics_model_i.sendPulse(4);
        watch(30, 1'h0, seen);
        chk(seen, 1'h0);
        // Pass setting with the gate open hands the event level straight on
        axw(8'h34, 32'hFF, 2'h0);
        @(negedge clk);
        chk(usartRx, 1'h0);
        @(posedge clk);
        eventIn <= 1'h1;
        repeat (2) @(negedge clk);
        chk(usartRx, 1'h1);
        complete_run();
    end
endmodule : infrared_comm_mode_pulse_codec_bench

// *** ircp_codec.sv ***
// Infrared pulse codec between a USART bit stream and an infrared transceiver,
// with its control registers on an AXI4-Lite slave.
// Assumes all inputs are synchronous to clk and a single clock domain.
`include "ircp_defs.svh"
module ircp_codec (
    input  wire logic        clk,
    input  wire logic        nrst,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // USART side
    input  wire logic        txBitValid,
    input  wire logic        txBitData,
    output logic             txBitReady,
    output logic             usartRx,
    // Transceiver side and event channel
    output logic             irTx,
    input  wire logic        irRx,
    input  wire logic        eventIn
);
    ircp_pkg::ircp_cfg_t      cfg;
    ircp_pkg::ircp_tx_state_t txState;
    ircp_pkg::ircp_tx_state_t next_txState;

    // Bus slave state
    logic [5:0]  awIdx;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        awHeld;
    logic        wHeld;

    // Register index decode from a byte address
    function automatic logic mapped(input logic [7:0] a);
        mapped = a[1:0] == 2'b00 && (a[7:2] == `IRCP_IDX_EVENT || a[7:2] == `IRCP_IDX_TX_PULSE
              || a[7:2] == `IRCP_IDX_RX_PULSE || a[7:2] == `IRCP_IDX_USART
              || a[7:2] == `IRCP_IDX_BAUD || a[7:2] == `IRCP_IDX_STATUS);
    endfunction : mapped

    // Pulse length in clocks for a setting and baud period
    function automatic logic [15:0] pulseLen(input logic [7:0] pl, input logic [15:0] bp);
        logic [17:0] shortLen;
        shortLen = (18'(bp) * 18'(`IRCP_SHORT_NUM)) >> `IRCP_SHORT_SHIFT;
        if (pl != `IRCP_TX_SHORT) begin
            pulseLen = 16'(pl);
        end else begin
            pulseLen = (shortLen == 18'h0) ? 16'h0001 : shortLen[15:0];
        end
    endfunction : pulseLen

    // Mode decode
    wire        isIr     = cfg.commModeSelect == `IRCP_MODE_IR;
    wire        txPass   = !isIr || cfg.txPulseSetting == `IRCP_TX_PASS;
    wire        rxCoded  = isIr && cfg.txPulseSetting != `IRCP_TX_PASS;
    wire [15:0] baudLen  = (cfg.baudPeriod == 16'h0) ? 16'h0001 : cfg.baudPeriod;
    wire [15:0] pulseNow = pulseLen(cfg.txPulseSetting, baudLen);

    // Bus handshakes and decode
    wire       awTake  = s_axi_awvalid && s_axi_awready;
    wire       wTake   = s_axi_wvalid && s_axi_wready;
    wire       arTake  = s_axi_arvalid && s_axi_arready;
    wire       doWrite = awHeld && wHeld && !s_axi_bvalid;
    wire       wrOk    = mapped({awIdx, 2'b00}) && awIdx != `IRCP_IDX_STATUS;
    wire       rdOk    = mapped(s_axi_araddr);
    wire [5:0] rdIdx   = s_axi_araddr[7:2];

    // Transmit path wires
    logic [15:0] baudCnt;
    logic [15:0] pulseCnt;
    logic        curBit;
    wire         baudTick = cfg.transmitterEnableBit && baudCnt == 16'h0;
    wire         fifoValid;
    wire         fifoData;
    wire         startPulse = baudTick && !txPass && fifoValid && !fifoData;

    // Receive path wires
    logic [15:0] lowCnt;
    logic [15:0] next_lowCnt;
    wire         pulseAccept;
    wire         rxSrc   = (isIr && !cfg.infraredEventInGate) ? eventIn : irRx;
    // setting used live, loaded before enable
    wire [6:0]   filtCoef = isIr ? cfg.rxFilterSetting : 7'h00;
    wire         rxDemod  = cfg.receiverEnableBit && rxCoded;

    // Read data selection
    wire [31:0] status = {28'h0, txState == ircp_pkg::TX_PULSE, fifoValid, lowCnt != 16'h0,
                          rxSrc};
    wire [31:0] rdMux =
        (rdIdx == `IRCP_IDX_EVENT)    ? {31'h0, cfg.infraredEventInGate} :
        (rdIdx == `IRCP_IDX_TX_PULSE) ? {24'h0, cfg.txPulseSetting} :
        (rdIdx == `IRCP_IDX_RX_PULSE) ? {25'h0, cfg.rxFilterSetting} :
        (rdIdx == `IRCP_IDX_USART)  ? {28'h0, cfg.receiverEnableBit, cfg.transmitterEnableBit,
                                       cfg.commModeSelect} :
        (rdIdx == `IRCP_IDX_BAUD)   ? {16'h0, cfg.baudPeriod} : status;

    // Write channel: address and data are taken in either order
    always_ff @(posedge clk) begin
        if (!nrst) begin
            awIdx         <= 6'h0;
            wData         <= 32'h0;
            wStrb         <= 4'h0;
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `IRCP_RESP_OKAY;
        end else begin
            if (awTake) begin
                awIdx         <= s_axi_awaddr[7:2];
                awHeld        <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (wTake) begin
                wData        <= s_axi_wdata;
                wStrb        <= s_axi_wstrb;
                wHeld        <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrOk ? `IRCP_RESP_OKAY : `IRCP_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                awHeld        <= 1'b0;
                wHeld         <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Register file; byte lane 0 holds the fields, lane 1 the baud high byte
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cfg                 <= '0;
            cfg.txPulseSetting  <= `IRCP_RST_BYTE;
            cfg.rxFilterSetting <= 7'(`IRCP_RST_BYTE);
            cfg.baudPeriod      <= `IRCP_RST_BAUD;
        end else if (doWrite && wStrb[0]) begin
            case (awIdx)
                `IRCP_IDX_EVENT:    cfg.infraredEventInGate <= wData[0];
                `IRCP_IDX_TX_PULSE: cfg.txPulseSetting <= wData[7:0];
                `IRCP_IDX_RX_PULSE: cfg.rxFilterSetting <= wData[6:0];
                `IRCP_IDX_USART: begin
                    cfg.commModeSelect       <= wData[`IRCP_F_MODE_HI:`IRCP_F_MODE_LO];
                    cfg.transmitterEnableBit <= wData[`IRCP_F_TX_ON];
                    cfg.receiverEnableBit    <= wData[`IRCP_F_RX_ON];
                end
                `IRCP_IDX_BAUD: begin
                    cfg.baudPeriod[7:0] <= wData[7:0];
                    if (wStrb[1]) begin
                        cfg.baudPeriod[15:8] <= wData[15:8];
                    end
                end
                default: ;
            endcase
        end else if (doWrite && wStrb[1] && awIdx == `IRCP_IDX_BAUD) begin
            cfg.baudPeriod[15:8] <= wData[15:8];
        end
    end

    // Read channel; one read at a time, answer one cycle after the address
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `IRCP_RESP_OKAY;
        end else if (arTake) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdOk ? rdMux : 32'h0;
            s_axi_rresp   <= rdOk ? `IRCP_RESP_OKAY : `IRCP_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Bit buffer: the modulator drains one bit per baud tick, so a slow link stalls the source
    ircp_fifo2 #(
        .WIDTH (1),
        .DEPTH (2)
    ) ircp_fifo2_i (
        .clk      (clk),
        .nrst     (nrst),
        .inValid  (txBitValid),
        .inData   (txBitData),
        .inReady  (txBitReady),
        .outValid (fifoValid),
        .outData  (fifoData),
        .outReady (baudTick)
    );

    // pulse state sequencing
    // A tick always restarts the sequence, so a pulse longer than a baud period is cut
    always_comb begin
        next_txState = txState;
        if (!cfg.transmitterEnableBit) begin
            next_txState = ircp_pkg::TX_IDLE;
        end else if (baudTick) begin
            next_txState = startPulse ? ircp_pkg::TX_PULSE : ircp_pkg::TX_SPACE;
        end else begin
            case (txState)
                ircp_pkg::TX_PULSE: next_txState = (pulseCnt == 16'h0) ? ircp_pkg::TX_SPACE
                                                                       : ircp_pkg::TX_PULSE;
                ircp_pkg::TX_SPACE: next_txState = ircp_pkg::TX_SPACE;
                ircp_pkg::TX_IDLE:  next_txState = ircp_pkg::TX_IDLE;
                default:            next_txState = ircp_pkg::TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            txState  <= ircp_pkg::TX_IDLE;
            baudCnt  <= 16'h0;
            pulseCnt <= 16'h0;
            curBit   <= 1'b1;
        end else begin
            txState <= next_txState;
            if (!cfg.transmitterEnableBit) begin
                baudCnt <= 16'h0;
                curBit  <= 1'b1;
            end else if (baudTick) begin
                baudCnt  <= baudLen - 16'h1;
                pulseCnt <= pulseNow - 16'h1;
                curBit   <= fifoValid ? fifoData : 1'b1;
            end else begin
                baudCnt <= baudCnt - 16'h1;
                if (pulseCnt != 16'h0) begin
                    pulseCnt <= pulseCnt - 16'h1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            irTx <= 1'b1;
        end else if (txPass) begin
            irTx <= (cfg.transmitterEnableBit && baudTick && fifoValid) ? fifoData
                  : (cfg.transmitterEnableBit && !baudTick) ? curBit : 1'b1;
        end else begin
            irTx <= next_txState == ircp_pkg::TX_PULSE;
        end
    end

    // Receive filter
    ircp_rx_filter ircp_rx_filter_i (
        .clk      (clk),
        .nrst     (nrst),
        .rawPulse (rxSrc && rxDemod),
        .coeff    (filtCoef),
        .accept   (pulseAccept)
    );

    assign next_lowCnt = !rxDemod ? 16'h0 : pulseAccept ? baudLen
                       : (lowCnt != 16'h0) ? lowCnt - 16'h1 : 16'h0;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            lowCnt  <= 16'h0;
            usartRx <= 1'b1;
        end else begin
            lowCnt  <= next_lowCnt;
            usartRx <= rxCoded ? (!cfg.receiverEnableBit || next_lowCnt == 16'h0) : rxSrc;
        end
    end

    // Helper: length of the current high run on irTx
    logic [15:0] hiRun;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            hiRun <= 16'h0;
        end else begin
            hiRun <= irTx ? hiRun + 16'h1 : 16'h0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_non_ir_rx: assert property (!isIr |=> usartRx == $past(irRx))
        else $error("receive not passed through outside infrared mode");
    a_event_gate_open: assert property (isIr && !cfg.infraredEventInGate && txPass
        |=> usartRx == $past(eventIn))
        else $error("event input not routed while gate enabled");
    a_setting_ignored: assert property (!isIr && cfg.transmitterEnableBit
        |=> txState != ircp_pkg::TX_PULSE)
        else $error("pulse coding outside infrared mode");
    // The high run counter already holds the full pulse at the edge that sees the fall
    a_short_pulse_len: assert property (!txPass && cfg.txPulseSetting == 8'h00
        && $stable(cfg) && $fell(irTx) && $past(txState) == ircp_pkg::TX_PULSE
        && pulseNow < baudLen |-> hiRun == pulseNow)
        else $error("short pulse length wrong");
    a_fixed_pulse_len: assert property (!txPass && cfg.txPulseSetting != 8'h00
        && $stable(cfg) && $fell(irTx) && $past(txState) == ircp_pkg::TX_PULSE
        && pulseNow < baudLen |-> hiRun == 16'(cfg.txPulseSetting))
        else $error("fixed pulse length wrong");
    a_pulse_on_tick: assert property (!txPass && $rose(irTx) |-> $past(baudTick))
        else $error("pulse not started on baud tick");
    a_tx_pass: assert property (txPass && cfg.transmitterEnableBit && !baudTick
        && $stable(cfg) |=> irTx == $past(curBit))
        else $error("transmit bit altered in pass-through");
    a_zero_bit_pulse: assert property (startPulse && $stable(cfg)
        |=> irTx ##1 (irTx || pulseNow == 16'h1))
        else $error("zero bit did not produce a pulse");
    a_demod_low: assert property (pulseAccept && rxDemod && $stable(cfg)
        |=> !usartRx)
        else $error("accepted pulse not restored as a zero bit");
endmodule : ircp_codec

// *** ircp_defs.svh ***
// Offsets, field positions, reset values and codes of the infrared pulse codec.
// Assumes inclusion by bare name from the design modules.
`ifndef IRCP_DEFS_SVH
`define IRCP_DEFS_SVH

// Register indices; the byte address is four times the index
`define IRCP_IDX_EVENT    6'h0C
`define IRCP_IDX_TX_PULSE 6'h0D
`define IRCP_IDX_RX_PULSE 6'h0E
`define IRCP_IDX_USART    6'h10
`define IRCP_IDX_BAUD     6'h11
`define IRCP_IDX_STATUS   6'h12

// Reset values
`define IRCP_RST_BYTE     8'h00
`define IRCP_RST_BAUD     16'h0010

// Field positions in the USART control register
`define IRCP_F_MODE_LO    0
`define IRCP_F_MODE_HI    1
`define IRCP_F_TX_ON      2
`define IRCP_F_RX_ON      3

// Codes
`define IRCP_MODE_IR      2'h2
`define IRCP_TX_SHORT     8'h00
`define IRCP_TX_PASS      8'hFF
`define IRCP_RESP_OKAY    2'h0
`define IRCP_RESP_SLVERR  2'h2

// Short pulse is 3/16 of a baud period
`define IRCP_SHORT_NUM    3
`define IRCP_SHORT_SHIFT  4

`endif

// *** ircp_fifo2.sv ***
// Small valid/ready buffer, two entries by default, between bit source and modulator.
// Assumes one clock and a synchronous active-low reset.
module ircp_fifo2 #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    output logic [WIDTH-1:0]      outData,
    input  wire logic             outReady
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr;
    logic [PW-1:0]    rdPtr;
    logic [CW-1:0]    count;
    logic [CW-1:0]    next_count;
    wire              push = inValid && inReady;
    wire              pop  = outValid && outReady;

    // Count follows push and pop; flags are registered so stalls show at once
    assign next_count = count + CW'(push) - CW'(pop);
    assign outData    = mem[rdPtr];

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : bump

    // Pointer and flag update
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wrPtr    <= '0;
            rdPtr    <= '0;
            count    <= '0;
            inReady  <= 1'b1;
            outValid <= 1'b0;
        end else begin
            if (push) begin
                mem[wrPtr] <= inData;
                wrPtr      <= bump(wrPtr);
            end
            if (pop) begin
                rdPtr <= bump(rdPtr);
            end
            count    <= next_count;
            inReady  <= next_count != CW'(DEPTH);
            outValid <= next_count != '0;
        end
    end

    a_fifo_no_overflow: assert property (@(posedge clk) disable iff (!nrst)
        count == CW'(DEPTH) |-> !inReady) else $error("buffer full but ready high");
endmodule : ircp_fifo2

// *** ircp_optics_model.sv ***
// Infrared transceiver model: drives the receive light level seen by the codec.
// Assumes clk is the codec clock; no light reads as a low level.
module ircp_optics_model (
    input  wire logic clk,
    input  wire logic irTx,
    output logic      irRx
);
    timeunit 1ns;
    timeprecision 1ns;
    initial irRx = 1'h0;
    // Level changes land just after an edge, never on the sampling edge
    task automatic setLevel(input logic v);
        @(posedge clk);
        irRx <= v;
    endtask : setLevel
    // one light pulse per zero bit
    task automatic sendPulse(input int len);
        setLevel(1'h1);
        repeat (len) @(posedge clk);
        irRx <= 1'h0;
    endtask : sendPulse
endmodule : ircp_optics_model

// *** ircp_pkg.sv ***
// Types shared by the infrared pulse codec modules.
// Assumes ircp_defs.svh is on the include path.
package ircp_pkg;

    // Configuration as written by software
    typedef struct packed {
        logic [1:0]  commModeSelect;
        logic        transmitterEnableBit;
        logic        receiverEnableBit;
        logic        infraredEventInGate;
        logic [7:0]  txPulseSetting;
        logic [6:0]  rxFilterSetting;
        logic [15:0] baudPeriod;
    } ircp_cfg_t;

    // Transmit modulator states
    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_PULSE = 2'b01,
        TX_SPACE = 2'b10
    } ircp_tx_state_t;

endpackage : ircp_pkg

// *** ircp_rx_filter.sv ***
// Receive pulse filter: counts consecutive high samples and flags an accepted pulse.
// Assumes the raw input is already synchronous to clk.
`include "ircp_defs.svh"
module ircp_rx_filter (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       rawPulse,
    input  wire logic [6:0] coeff,
    output logic            accept
);
    logic [7:0] runCnt;
    wire        hit = rawPulse && (runCnt == {1'b0, coeff});

    // sample count filter
    // Coefficient zero takes the first high sample, otherwise coeff+1 samples
    always_ff @(posedge clk) begin
        if (!nrst) begin
            runCnt <= 8'h00;
            accept <= 1'b0;
        end else begin
            if (!rawPulse) begin
                runCnt <= 8'h00;
            end else if (runCnt != 8'hFF) begin
                runCnt <= runCnt + 8'h01;
            end
            accept <= hit;
        end
    end

    a_filter_run_length: assert property (@(posedge clk) disable iff (!nrst)
        accept |-> $past(rawPulse) && runCnt == {1'b0, $past(coeff)} + 8'h01)
        else $error("pulse accepted after wrong sample count");
endmodule : ircp_rx_filter
